// ### include/dtc_pkg.sv
// Constants, register map and types for the DRAM termination control block.
// Assumes a 100 MHz system clock and an AHB-Lite register bus.
package dtc_pkg;
   // System clock and asynchronous termination delays
   localparam int CLK_PERIOD_PS = 10000;
   localparam int ASYNC_MIN_PS = 2000;
   localparam int ASYNC_MAX_PS = 8500;
   localparam int ASYNC_MIN_RAW = (ASYNC_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int ASYNC_MAX_RAW = ASYNC_MAX_PS / CLK_PERIOD_PS;
   localparam int ASYNC_MIN_CYC = (ASYNC_MIN_RAW < 1) ? 1 : ASYNC_MIN_RAW;
   localparam int ASYNC_MAX_CYC = (ASYNC_MAX_RAW < ASYNC_MIN_CYC) ? ASYNC_MIN_CYC : ASYNC_MAX_RAW;

   // Field widths
   localparam int RTT_NOM_W = 3;
   localparam int RTT_WR_W = 2;
   localparam int LAT_W = 5;
   localparam int CNT_W = 6;
   localparam int CPDED_W = 8;
   localparam int RFC_W = 10;
   localparam int ADDR_W = 8;
   localparam int ACNT_W = 4;

   // Latency offsets, in memory clock cycles
   localparam logic [CNT_W-1:0] ODT_LAT_SUB = 6'h02;
   localparam logic [CNT_W-1:0] LEAD_SUB = 6'h01;
   localparam logic [CNT_W-1:0] CWN_FULL_ADD = 6'h06;
   localparam logic [CNT_W-1:0] CWN_CHOP_ADD = 6'h04;
   localparam logic [CNT_W-1:0] HOLD_SHORT = 6'h04;
   localparam logic [CNT_W-1:0] HOLD_LONG = 6'h06;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] REG_MODE_FIRST = 8'h00;
   localparam logic [ADDR_W-1:0] REG_MODE_SECOND = 8'h04;
   localparam logic [ADDR_W-1:0] REG_MODE_THIRD = 8'h08;
   localparam logic [ADDR_W-1:0] REG_PD_TIMING = 8'h0C;
   localparam logic [ADDR_W-1:0] REG_STATUS = 8'h10;

   // Field positions
   localparam int MF_PD_DLL_BIT = 12;
   localparam int MS_NOM_B0 = 2;
   localparam int MS_NOM_B1 = 6;
   localparam int MS_NOM_B2 = 9;
   localparam int MS_AL_LSB = 16;
   localparam int MT_WR_LSB = 9;
   localparam int MT_CWL_LSB = 16;
   localparam int PT_CPDED_LSB = 0;
   localparam int PT_RFC_LSB = 16;
   localparam int ST_TERM_BIT = 0;
   localparam int ST_WR_BIT = 1;
   localparam int ST_ASYNC_BIT = 2;
   localparam int ST_TRANS_BIT = 3;
   localparam int ST_PD_BIT = 4;
   localparam int ST_CODE_LSB = 8;

   // Reset values
   localparam logic [LAT_W-1:0] RST_CWL = 5'h05;
   localparam logic [LAT_W-1:0] RST_AL = 5'h00;
   localparam logic [RTT_NOM_W-1:0] RST_RTT_NOM = 3'h0;
   localparam logic [RTT_WR_W-1:0] RST_RTT_WR = 2'h0;
   localparam logic RST_PD_DLL = 1'h0;
   localparam logic [CPDED_W-1:0] RST_CPDED = 8'h01;
   localparam logic [RFC_W-1:0] RST_RFC = 10'h040;

   // AHB encodings
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam int HTRANS_ACT_BIT = 1;

   // Synchronised pin positions
   localparam int NPIN = 6;
   localparam int PIN_CK = 0;
   localparam int PIN_ODT = 1;
   localparam int PIN_CKE = 2;
   localparam int PIN_WR = 3;
   localparam int PIN_BC4 = 4;
   localparam int PIN_REF = 5;

   typedef enum logic [1:0] {MODE_SYNC, MODE_TRANS, MODE_ASYNC} dtc_mode_t;
endpackage

// ### include/dtc_cfg_if.sv
// Configuration and status carrier between register file and control core.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface dtc_cfg_if;
   logic [dtc_pkg::RTT_NOM_W-1:0] rtt_nom;
   logic [dtc_pkg::RTT_WR_W-1:0] rtt_wr;
   logic [dtc_pkg::LAT_W-1:0] al;
   logic [dtc_pkg::LAT_W-1:0] cwl;
   logic pd_dll_on;
   logic [dtc_pkg::CPDED_W-1:0] cpded;
   logic [dtc_pkg::RFC_W-1:0] rfc;
   logic st_term;
   logic st_wr_sel;
   logic st_async;
   logic st_trans;
   logic st_pd;
   logic [dtc_pkg::RTT_NOM_W-1:0] st_code;

   modport regs (
      output rtt_nom, rtt_wr, al, cwl, pd_dll_on, cpded, rfc,
      input st_term, st_wr_sel, st_async, st_trans, st_pd, st_code
   );
   modport core (
      input rtt_nom, rtt_wr, al, cwl, pd_dll_on, cpded, rfc,
      output st_term, st_wr_sel, st_async, st_trans, st_pd, st_code
   );
endinterface
`default_nettype wire

// ### design/dtc_regs.sv
// AHB-Lite register file for the termination control block.
// Assumes a single master, zero wait states, word accesses only.
`timescale 1ns/1ps
`default_nettype none
module dtc_regs (
   input wire logic mclk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   dtc_cfg_if.regs cfg
);
   logic acc;
   logic hit;
   logic wr_pend_r, wr_pend_nxt;
   logic [dtc_pkg::ADDR_W-1:0] waddr_r, waddr_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [dtc_pkg::RTT_NOM_W-1:0] nom_r, nom_nxt;
   logic [dtc_pkg::RTT_WR_W-1:0] wrt_r, wrt_nxt;
   logic [dtc_pkg::LAT_W-1:0] al_r, al_nxt;
   logic [dtc_pkg::LAT_W-1:0] cwl_r, cwl_nxt;
   logic pd_dll_r, pd_dll_nxt;
   logic [dtc_pkg::CPDED_W-1:0] cpded_r, cpded_nxt;
   logic [dtc_pkg::RFC_W-1:0] rfc_r, rfc_nxt;

   assign acc = hsel && htrans[dtc_pkg::HTRANS_ACT_BIT] && hready;
   // Upper address bits must be zero; anything else is unmapped
   assign hit = (haddr[31:dtc_pkg::ADDR_W] == '0);

   always_comb begin
      wr_pend_nxt = acc && hit && hwrite && (hsize == dtc_pkg::HSIZE_WORD);
      waddr_nxt = haddr[dtc_pkg::ADDR_W-1:0];
      nom_nxt = nom_r;
      wrt_nxt = wrt_r;
      al_nxt = al_r;
      cwl_nxt = cwl_r;
      pd_dll_nxt = pd_dll_r;
      cpded_nxt = cpded_r;
      rfc_nxt = rfc_r;
      if (wr_pend_r) begin
         case (waddr_r)
            dtc_pkg::REG_MODE_FIRST: pd_dll_nxt = hwdata[dtc_pkg::MF_PD_DLL_BIT];
            dtc_pkg::REG_MODE_SECOND: begin
               nom_nxt = {hwdata[dtc_pkg::MS_NOM_B2], hwdata[dtc_pkg::MS_NOM_B1], hwdata[dtc_pkg::MS_NOM_B0]};
               al_nxt = hwdata[dtc_pkg::MS_AL_LSB +: dtc_pkg::LAT_W];
            end
            dtc_pkg::REG_MODE_THIRD: begin
               wrt_nxt = hwdata[dtc_pkg::MT_WR_LSB +: dtc_pkg::RTT_WR_W];
               cwl_nxt = hwdata[dtc_pkg::MT_CWL_LSB +: dtc_pkg::LAT_W];
            end
            dtc_pkg::REG_PD_TIMING: begin
               cpded_nxt = hwdata[dtc_pkg::PT_CPDED_LSB +: dtc_pkg::CPDED_W];
               rfc_nxt = hwdata[dtc_pkg::PT_RFC_LSB +: dtc_pkg::RFC_W];
            end
            default: ;
         endcase
      end
      // Read data is fetched in the address phase so it stands from a flop
      rdata_nxt = '0;
      if (acc && hit && !hwrite) begin
         case (haddr[dtc_pkg::ADDR_W-1:0])
            dtc_pkg::REG_MODE_FIRST: rdata_nxt[dtc_pkg::MF_PD_DLL_BIT] = pd_dll_r;
            dtc_pkg::REG_MODE_SECOND: begin
               rdata_nxt[dtc_pkg::MS_NOM_B0] = nom_r[0];
               rdata_nxt[dtc_pkg::MS_NOM_B1] = nom_r[1];
               rdata_nxt[dtc_pkg::MS_NOM_B2] = nom_r[2];
               rdata_nxt[dtc_pkg::MS_AL_LSB +: dtc_pkg::LAT_W] = al_r;
            end
            dtc_pkg::REG_MODE_THIRD: begin
               rdata_nxt[dtc_pkg::MT_WR_LSB +: dtc_pkg::RTT_WR_W] = wrt_r;
               rdata_nxt[dtc_pkg::MT_CWL_LSB +: dtc_pkg::LAT_W] = cwl_r;
            end
            dtc_pkg::REG_PD_TIMING: begin
               rdata_nxt[dtc_pkg::PT_CPDED_LSB +: dtc_pkg::CPDED_W] = cpded_r;
               rdata_nxt[dtc_pkg::PT_RFC_LSB +: dtc_pkg::RFC_W] = rfc_r;
            end
            dtc_pkg::REG_STATUS: begin
               rdata_nxt[dtc_pkg::ST_TERM_BIT] = cfg.st_term;
               rdata_nxt[dtc_pkg::ST_WR_BIT] = cfg.st_wr_sel;
               rdata_nxt[dtc_pkg::ST_ASYNC_BIT] = cfg.st_async;
               rdata_nxt[dtc_pkg::ST_TRANS_BIT] = cfg.st_trans;
               rdata_nxt[dtc_pkg::ST_PD_BIT] = cfg.st_pd;
               rdata_nxt[dtc_pkg::ST_CODE_LSB +: dtc_pkg::RTT_NOM_W] = cfg.st_code;
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         wr_pend_r <= 1'b0;
         waddr_r <= '0;
         rdata_r <= '0;
         nom_r <= dtc_pkg::RST_RTT_NOM;
         wrt_r <= dtc_pkg::RST_RTT_WR;
         al_r <= dtc_pkg::RST_AL;
         cwl_r <= dtc_pkg::RST_CWL;
         pd_dll_r <= dtc_pkg::RST_PD_DLL;
         cpded_r <= dtc_pkg::RST_CPDED;
         rfc_r <= dtc_pkg::RST_RFC;
      end else begin
         wr_pend_r <= wr_pend_nxt;
         waddr_r <= waddr_nxt;
         rdata_r <= rdata_nxt;
         nom_r <= nom_nxt;
         wrt_r <= wrt_nxt;
         al_r <= al_nxt;
         cwl_r <= cwl_nxt;
         pd_dll_r <= pd_dll_nxt;
         cpded_r <= cpded_nxt;
         rfc_r <= rfc_nxt;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_r;
   assign cfg.rtt_nom = nom_r;
   assign cfg.rtt_wr = wrt_r;
   assign cfg.al = al_r;
   assign cfg.cwl = cwl_r;
   assign cfg.pd_dll_on = pd_dll_r;
   assign cfg.cpded = cpded_r;
   assign cfg.rfc = rfc_r;
endmodule // dtc_regs
`default_nettype wire

// ### design/dtc_term_ctrl.sv
// On-die termination control core of a DDR3 memory device.
// Assumes memory-clock pins arrive asynchronously and are oversampled by mclk;
// the register file sits on AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module dtc_term_ctrl #(
   parameter int ODT_HIST_DEPTH = 32
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic sdram_ck,
   input wire logic odt_pin,
   input wire logic cke_pin,
   input wire logic wr_cmd_pin,
   input wire logic burst_chop_pin,
   input wire logic ref_cmd_pin,
   output logic term_en,
   output logic term_wr_sel,
   output logic [2:0] rtt_code,
   output logic async_mode,
   output logic trans_period
);
   localparam int HIST_IDX_W = $clog2(ODT_HIST_DEPTH);
   localparam int CNT_W = dtc_pkg::CNT_W;
   // Write history outlives the longest strength window
   localparam int WHIST_D = ODT_HIST_DEPTH + int'(dtc_pkg::CWN_FULL_ADD);

   dtc_cfg_if cfg ();

   dtc_regs u_regs (
      .mclk(mclk),
      .rst(rst),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .hreadyout(hreadyout),
      .hrdata(hrdata),
      .hresp(hresp),
      .cfg(cfg)
   );

   // Two-stage synchronisers for every pin, memory clock included
   logic [dtc_pkg::NPIN-1:0] pin_raw;
   logic [dtc_pkg::NPIN-1:0] meta_r;
   logic [dtc_pkg::NPIN-1:0] pin_s_r;

   assign pin_raw = {ref_cmd_pin, burst_chop_pin, wr_cmd_pin, cke_pin, odt_pin, sdram_ck};

   always_ff @(posedge mclk) begin
      if (rst) begin
         meta_r <= '0;
         pin_s_r <= '0;
      end else begin
         meta_r <= pin_raw;
         pin_s_r <= meta_r;
      end
   end

   // Link-side state
   logic ck_prev_r, ck_prev_nxt;
   logic cke_prev_r, cke_prev_nxt;
   logic [ODT_HIST_DEPTH-1:0] hist_r, hist_nxt;
   logic [WHIST_D-1:0] whist_r, whist_nxt;
   logic [WHIST_D-1:0] chist_r, chist_nxt;
   logic [dtc_pkg::RFC_W-1:0] rfc_left_r, rfc_left_nxt;
   logic [dtc_pkg::RFC_W-1:0] tcnt_r, tcnt_nxt;
   dtc_pkg::dtc_mode_t mode_r, mode_nxt;
   logic pend_on_r, pend_on_nxt;
   logic pend_wr_r, pend_wr_nxt;
   logic term_on_r, term_on_nxt;
   logic wr_sel_r, wr_sel_nxt;
   logic [2:0] code_r, code_nxt;
   logic [dtc_pkg::ACNT_W-1:0] acnt_r, acnt_nxt;
   logic trans_r, trans_nxt;
   logic async_r, async_nxt;
   logic pd_r, pd_nxt;

   // Decoded configuration and sampled pins
   logic rise;
   logic fall;
   logic odt_s;
   logic cke_s;
   logic wr_s;
   logic bc4_s;
   logic ref_s;
   logic dyn_en;
   logic odt_enable;
   logic [CNT_W-1:0] wl;
   logic [CNT_W-1:0] lat;
   logic wr_new;
   logic [WHIST_D:0] wr_at;
   logic [WHIST_D:0] chop_at;
   logic [WHIST_D:0] wr_hit;
   logic [HIST_IDX_W-1:0] lat_idx;
   logic [dtc_pkg::RFC_W-1:0] entry_end;

   assign rise = pin_s_r[dtc_pkg::PIN_CK] && !ck_prev_r;
   assign fall = !pin_s_r[dtc_pkg::PIN_CK] && ck_prev_r;
   assign odt_s = pin_s_r[dtc_pkg::PIN_ODT];
   assign cke_s = pin_s_r[dtc_pkg::PIN_CKE];
   assign wr_s = pin_s_r[dtc_pkg::PIN_WR];
   assign bc4_s = pin_s_r[dtc_pkg::PIN_BC4];
   assign ref_s = pin_s_r[dtc_pkg::PIN_REF];

   assign dyn_en = (cfg.rtt_wr != '0);
   assign odt_enable = (cfg.rtt_nom != '0) || dyn_en;
   // Write latency includes additive latency; both pin latencies are WL-2
   assign wl = CNT_W'(cfg.cwl) + CNT_W'(cfg.al);
   assign lat = wl - dtc_pkg::ODT_LAT_SUB;
   // Lead time before entry; entry is only known once CKE is seen low,
   // so that lead stretch is answered synchronously, which the period allows
   assign lat_idx = lat[HIST_IDX_W-1:0];
   // Commands are only decoded with CKE high
   assign wr_new = cke_s && wr_s && dyn_en;
   assign wr_at = {whist_r, wr_new};
   assign chop_at = {chist_r, bc4_s};

   // Every write keeps its own window; a later write must not cut the
   // stretch short while it still waits out its own latency
   for (genvar d = 0; d <= WHIST_D; d++) begin : g_wr_win
      logic [CNT_W-1:0] span;
      assign span = chop_at[d] ? dtc_pkg::CWN_CHOP_ADD : dtc_pkg::CWN_FULL_ADD;
      assign wr_hit[d] = wr_at[d] && (CNT_W'(d) >= lat) && (CNT_W'(d) - lat < span);
   end

   always_comb begin
      ck_prev_nxt = pin_s_r[dtc_pkg::PIN_CK];
      cke_prev_nxt = cke_prev_r;
      hist_nxt = hist_r;
      whist_nxt = whist_r;
      chist_nxt = chist_r;
      rfc_left_nxt = rfc_left_r;
      tcnt_nxt = tcnt_r;
      mode_nxt = mode_r;
      pend_on_nxt = pend_on_r;
      pend_wr_nxt = pend_wr_r;
      term_on_nxt = term_on_r;
      wr_sel_nxt = wr_sel_r;
      acnt_nxt = acnt_r;
      trans_nxt = trans_r;
      async_nxt = async_r;
      pd_nxt = pd_r;
      entry_end = '0;

      if (rise) begin
         cke_prev_nxt = cke_s;
         pd_nxt = !cke_s;
         // Pin receiver stays live in power-down
         hist_nxt = {hist_r[ODT_HIST_DEPTH-2:0], odt_s};

         // Refresh time still to run, counted in memory clocks
         if (cke_s && ref_s) begin
            rfc_left_nxt = cfg.rfc;
         end else if (rfc_left_r != '0) begin
            rfc_left_nxt = rfc_left_r - 1'b1;
         end

         whist_nxt = wr_at[WHIST_D-1:0];
         chist_nxt = chop_at[WHIST_D-1:0] & wr_at[WHIST_D-1:0];

         pend_on_nxt = hist_nxt[lat_idx] && odt_enable;
         // Write strength from WL-2 up to the return point
         pend_wr_nxt = dyn_en && (|wr_hit);

         unique case (mode_r)
            dtc_pkg::MODE_SYNC: begin
               // Entry counts as cycle zero; the lead stretch before it is excluded
               if (!cke_s && cke_prev_r && !cfg.pd_dll_on) begin
                  entry_end = (rfc_left_nxt > dtc_pkg::RFC_W'(cfg.cpded)) ?
                     rfc_left_nxt : dtc_pkg::RFC_W'(cfg.cpded);
                  tcnt_nxt = entry_end;
                  mode_nxt = dtc_pkg::MODE_TRANS;
               end
            end
            dtc_pkg::MODE_TRANS: begin
               if (cke_s) begin
                  mode_nxt = dtc_pkg::MODE_SYNC;
               end else if (tcnt_r == '0) begin
                  // End instant was the previous edge and stayed inside
                  mode_nxt = dtc_pkg::MODE_ASYNC;
               end else begin
                  tcnt_nxt = tcnt_r - 1'b1;
               end
            end
            dtc_pkg::MODE_ASYNC: begin
               if (cke_s) begin
                  mode_nxt = dtc_pkg::MODE_SYNC;
               end
            end
         endcase
         trans_nxt = (mode_nxt == dtc_pkg::MODE_TRANS);
         async_nxt = (mode_nxt == dtc_pkg::MODE_ASYNC);
      end

      if (mode_r == dtc_pkg::MODE_ASYNC) begin
         // Pin applied straight, no additive or clocked latency
         wr_sel_nxt = 1'b0;
         if ((odt_s && odt_enable) != term_on_r) begin
            if (acnt_r >= dtc_pkg::ACNT_W'(dtc_pkg::ASYNC_MIN_CYC - 1)) begin
               term_on_nxt = odt_s && odt_enable;
               acnt_nxt = '0;
            end else begin
               acnt_nxt = acnt_r + 1'b1;
            end
         end else begin
            acnt_nxt = '0;
         end
      end else begin
         acnt_nxt = '0;
         // Commit on the falling edge: half a clock after the latency count.
         // Inside the transition the synchronous answer is kept, which lies
         // within the combined async/sync window for both directions.
         if (fall) begin
            term_on_nxt = pend_on_r;
            wr_sel_nxt = pend_wr_r;
         end
      end

      if (!term_on_nxt) begin
         code_nxt = '0;
      end else if (wr_sel_nxt) begin
         code_nxt = {1'b0, cfg.rtt_wr};
      end else begin
         code_nxt = cfg.rtt_nom;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         ck_prev_r <= 1'b0;
         cke_prev_r <= 1'b0;
         hist_r <= '0;
         whist_r <= '0;
         chist_r <= '0;
         rfc_left_r <= '0;
         tcnt_r <= '0;
         mode_r <= dtc_pkg::MODE_SYNC;
         pend_on_r <= 1'b0;
         pend_wr_r <= 1'b0;
         term_on_r <= 1'b0;
         wr_sel_r <= 1'b0;
         code_r <= '0;
         acnt_r <= '0;
         trans_r <= 1'b0;
         async_r <= 1'b0;
         pd_r <= 1'b0;
      end else begin
         ck_prev_r <= ck_prev_nxt;
         cke_prev_r <= cke_prev_nxt;
         hist_r <= hist_nxt;
         whist_r <= whist_nxt;
         chist_r <= chist_nxt;
         rfc_left_r <= rfc_left_nxt;
         tcnt_r <= tcnt_nxt;
         mode_r <= mode_nxt;
         pend_on_r <= pend_on_nxt;
         pend_wr_r <= pend_wr_nxt;
         term_on_r <= term_on_nxt;
         wr_sel_r <= wr_sel_nxt;
         code_r <= code_nxt;
         acnt_r <= acnt_nxt;
         trans_r <= trans_nxt;
         async_r <= async_nxt;
         pd_r <= pd_nxt;
      end
   end

   assign term_en = term_on_r;
   assign term_wr_sel = wr_sel_r;
   assign rtt_code = code_r;
   assign async_mode = async_r;
   assign trans_period = trans_r;

   assign cfg.st_term = term_on_r;
   assign cfg.st_wr_sel = wr_sel_r;
   assign cfg.st_async = async_r;
   assign cfg.st_trans = trans_r;
   assign cfg.st_pd = pd_r;
   assign cfg.st_code = code_r;
endmodule // dtc_term_ctrl
`default_nettype wire

// ### sim/dtc_ctl.sv
// Behavioural memory controller: free-running link clock, ODT, CKE and commands.
// Assumes the bench calls step once per link clock cycle.
`timescale 1ns/1ps
`default_nettype none
module dtc_ctl (
   output logic sdram_ck,
   output logic odt_pin,
   output logic cke_pin,
   output logic wr_cmd_pin,
   output logic burst_chop_pin,
   output logic ref_cmd_pin
);
   logic [2:0] hold;
   initial begin
      {odt_pin, wr_cmd_pin, burst_chop_pin, ref_cmd_pin} = 4'h0;
      cke_pin = 1'b1;
      hold = 3'h0;
      sdram_ck = 1'b0;
      #3.3;
      forever #62.5 sdram_ck = ~sdram_ck;
   end
   // Pins move on the falling edge, half a cycle clear of sampling
   task automatic step(input logic o, input logic c, input logic w, input logic b, input logic r);
      logic hi;
      @(negedge sdram_ck);
      hi = odt_pin;
      if (hold != 3'h0) hold = hold - 3'h1;
      odt_pin <= o || (hi && hold != 3'h0);
      if (o && !hi) hold = 3'h4;
      if (w && c && !b) hold = 3'h6;
      else if (w && c && hold < 3'h4) hold = 3'h4;
      cke_pin <= c;
      wr_cmd_pin <= w && c;
      burst_chop_pin <= b;
      ref_cmd_pin <= r && c;
   endtask
endmodule // dtc_ctl
`default_nettype wire

// ### sim/dtc_term_ctrl_chk.sv
// Concurrent checks on the termination control top-level ports.
// Assumes a 100 MHz mclk and a link clock far slower than it.
`timescale 1ns/1ps
`default_nettype none
module dtc_term_ctrl_chk (
   input wire logic mclk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic hresp,
   input wire logic cke_pin,
   input wire logic odt_pin,
   input wire logic term_en,
   input wire logic term_wr_sel,
   input wire logic [2:0] rtt_code,
   input wire logic async_mode,
   input wire logic trans_period
);
   logic [6:0] wr_cnt_r;
   logic [6:0] wr_cnt_nxt;
   logic [4:0] cke_cnt_r;
   logic [4:0] cke_cnt_nxt;
   always_comb begin
      wr_cnt_nxt = term_wr_sel ? wr_cnt_r + 7'((wr_cnt_r != 7'h7F)) : 7'h00;
      cke_cnt_nxt = cke_pin ? cke_cnt_r + 5'((cke_cnt_r != 5'h1F)) : 5'h00;
   end
   always_ff @(posedge mclk) begin
      wr_cnt_r <= rst ? 7'h00 : wr_cnt_nxt;
      cke_cnt_r <= rst ? 5'h00 : cke_cnt_nxt;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   sequence s_rd_idle; !(hsel && htrans[1] && !hwrite && hready); endsequence
   // Three cycles settled, so mode-entry updates are left out
   sequence s_async_held; async_mode ##1 async_mode ##1 async_mode; endsequence
   a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
   a_read_idle: assert property (s_rd_idle |=> hrdata == 32'h0) else $error("read data without read");
   a_rst_clear: assert property (disable iff (1'b0) rst |=> !term_en && !term_wr_sel && rtt_code == 3'h0
      && !async_mode && !trans_period && hrdata == 32'h0) else $error("outputs not cleared by reset");
   a_code_off: assert property (!term_en |-> rtt_code == 3'h0) else $error("code while off");
   a_wr_code: assert property (term_en && term_wr_sel |-> !rtt_code[2] && rtt_code != 3'h0)
      else $error("bad write strength code");
   a_modes_excl: assert property (!(async_mode && trans_period)) else $error("both modes");
   a_async_rise: assert property ($rose(async_mode) |-> $fell(trans_period)) else $error("async early");
   a_trans_entry: assert property ($rose(trans_period) |-> $past(cke_pin, 4) == 1'b0)
      else $error("transition without cke low");
   a_wake_sync: assert property (cke_cnt_r == 5'h1F |-> !trans_period && !async_mode)
      else $error("not synchronous while awake");
   a_wr_len: assert property ($fell(term_wr_sel) |-> wr_cnt_r >= 7'h28) else $error("short write strength");
   a_async_on: assert property (s_async_held ##0 $rose(term_en) |-> $past(odt_pin, 2))
      else $error("async on without pin");
   a_async_off: assert property (s_async_held ##0 $fell(term_en) |-> !$past(odt_pin, 2))
      else $error("async off with pin high");
endmodule // dtc_term_ctrl_chk
bind dtc_term_ctrl dtc_term_ctrl_chk u_dtc_term_ctrl_chk (.mclk, .rst, .hsel, .htrans, .hwrite, .hready,
   .hreadyout, .hrdata, .hresp, .cke_pin, .odt_pin, .term_en, .term_wr_sel, .rtt_code, .async_mode, .trans_period);
`default_nettype wire

// ### sim/dtc_term_ctrl_tb_top.sv
// Self-checking bench: registers over AHB-Lite, then termination timing.
// Assumes dtc_ctl drives the link pins and the checker is bound.
`timescale 1ns/1ps
`default_nettype none
module dtc_term_ctrl_tb_top;
   typedef struct packed {logic [2:0] nom; logic [1:0] wr; logic [4:0] al;} dtc_row_t;
   localparam dtc_row_t ROWS [5] = '{'{3'h1, 2'h2, 5'h00}, '{3'h5, 2'h1, 5'h02}, '{3'h2, 2'h0, 5'h00},
      '{3'h0, 2'h0, 5'h00}, '{3'h4, 2'h3, 5'h01}};
   logic mclk, rst, hsel, hwrite, hready, hreadyout, hresp, term_en, term_wr_sel, async_mode, trans_period;
   logic sdram_ck, odt_pin, cke_pin, wr_cmd_pin, burst_chop_pin, ref_cmd_pin;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0] htrans;
   logic [2:0] hsize, rtt_code, code;
   logic en, sel;
   dtc_row_t cfg;
   int errors, samples_checked, j, h, lat;
   assign hready = hreadyout;
   dtc_term_ctrl u_dtc_term_ctrl (.mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
      .hreadyout, .hrdata, .hresp, .sdram_ck, .odt_pin, .cke_pin, .wr_cmd_pin, .burst_chop_pin, .ref_cmd_pin,
      .term_en, .term_wr_sel, .rtt_code, .async_mode, .trans_period);
   dtc_ctl u_dtc_ctl (.sdram_ck, .odt_pin, .cke_pin, .wr_cmd_pin, .burst_chop_pin, .ref_cmd_pin);
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic ok, input string m);
      samples_checked++;
      if (!ok) begin
         errors++;
         $display("BAD %0t %s", $time, m);
      end
   endtask
   task automatic wait_rdy;
      int n;
      n = 0;
      @(posedge mclk);
      while (hready !== 1'b1 && n < 50) begin
         @(posedge mclk);
         n++;
      end
      if (n >= 50) begin
         errors++;
         close_out();
      end
   endtask
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
   endtask
   task automatic pd_case(input logic dll, input logic rf);
      ahb(1'b1, dtc_pkg::REG_MODE_FIRST, {19'h0, dll, 12'h000}, q);
      repeat (4) u_dtc_ctl.step(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
      u_dtc_ctl.step(1'b0, 1'b1, 1'b0, 1'b0, rf);
      for (j = 0; j < 13; j++) begin
         u_dtc_ctl.step(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
         chk(trans_period === (!dll && j >= 1 && j <= (rf ? 8 : 5)), "trans");
         chk(async_mode === (!dll && j >= (rf ? 9 : 6)), "async");
      end
      if (!dll) begin
         u_dtc_ctl.step(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
         repeat (2) @(posedge mclk);
         chk(term_en === 1'b0, "async early");
         repeat (2) @(posedge mclk);
         chk(term_en === 1'b1, "async on");
         ahb(1'b0, dtc_pkg::REG_STATUS, 32'h0, q);
         chk(q === 32'h0000_0115, "status");
         repeat (3) u_dtc_ctl.step(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
         u_dtc_ctl.step(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
         repeat (4) @(posedge mclk);
         chk(term_en === 1'b0, "async off");
      end
      repeat (3) u_dtc_ctl.step(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
      chk(async_mode === 1'b0 && trans_period === 1'b0, "wake");
      $display("power-down case dll %0d ref %0d done", dll, rf);
   endtask
   initial begin
      {rst, hsel, hwrite, htrans, haddr, hwdata} = {1'b1, 68'h0};
      hsize = dtc_pkg::HSIZE_WORD;
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      ahb(1'b0, dtc_pkg::REG_MODE_THIRD, 32'h0, q);
      chk(q === 32'h0005_0000, "third reset");
      ahb(1'b0, dtc_pkg::REG_PD_TIMING, 32'h0, q);
      chk(q === 32'h0040_0001, "timing reset");
      ahb(1'b0, 8'h40, 32'h0, q);
      chk(q === 32'h0, "unmapped read");
      $display("register test done");
      foreach (ROWS[r]) begin
         cfg = ROWS[r];
         ahb(1'b1, dtc_pkg::REG_MODE_SECOND, {11'h0, cfg.al, 6'h0, cfg.nom[2], 2'h0, cfg.nom[1], 3'h0,
            cfg.nom[0], 2'h0}, q);
         ahb(1'b1, dtc_pkg::REG_MODE_THIRD, {11'h0, 5'h05, 5'h00, cfg.wr, 9'h000}, q);
         lat = 3 + cfg.al;
         for (j = 0; j < 30; j++) begin
            u_dtc_ctl.step(j >= 2 && j < 13, 1'b1, j == 4 || j == 8, j == 8, 1'b0);
            h = j - lat - 2;
            en = (cfg.nom != 3'h0 || cfg.wr != 2'h0) && h >= 2 && h < 13;
            sel = cfg.wr != 2'h0 && h >= 4 && h < 12;
            code = en ? (sel ? {1'b0, cfg.wr} : cfg.nom) : 3'h0;
            chk(term_en === en, "term_en");
            chk(rtt_code === code, "rtt_code");
            if (en) chk(term_wr_sel === sel, "term_wr_sel");
         end
         $display("row %0d done", r);
      end
      ahb(1'b1, dtc_pkg::REG_MODE_SECOND, 32'h0000_0004, q);
      ahb(1'b1, dtc_pkg::REG_MODE_THIRD, 32'h0005_0000, q);
      ahb(1'b1, dtc_pkg::REG_PD_TIMING, 32'h0008_0004, q);
      pd_case(1'b1, 1'b0);
      pd_case(1'b0, 1'b0);
      pd_case(1'b0, 1'b1);
      repeat (8) u_dtc_ctl.step(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
      chk(term_en === 1'b1 && rtt_code === 3'h1, "on before reset");
      @(posedge mclk);
      rst <= 1'b1;
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      chk(term_en === 1'b0 && rtt_code === 3'h0 && async_mode === 1'b0, "reset clears");
      ahb(1'b0, dtc_pkg::REG_MODE_SECOND, 32'h0, q);
      chk(q === 32'h0, "second reset");
      $display("reset test done");
      close_out();
   end
endmodule // dtc_term_ctrl_tb_top
`default_nettype wire
